//--- design/tsp_stream_port.sv
// Contract
// - two local input streams, 32 channels each at 2.048 Mb/s, received
// - two local output streams at 2.048 Mb/s with three-state drive
// - multi-chip mode: expansion stream a is bidirectional at 8.192 Mb/s
// - timeslot mode: stream a is output only, rate 2.048/4.096/8.192
// - multi-chip mode: expansion stream b is bidirectional at 8.192 Mb/s
// - timeslot mode: stream b is input only, rate 2.048/4.096/8.192
// - rx packet-end strobe one bit after closing flag ends rx packet
// - tx bit-clock gate output selects the transmitted bit times
// - rx bit-clock gate output selects the received bit times
// - d-channel serial input accepted in the standard frame format
// - output-enable pin low floats all serial outputs; per-channel float else
// - reset low clears counters and registers and floats serial outputs
`timescale 1ns/100ps
module tsp_stream_port #(
  parameter int CLK_KHZ = tsp_pkg::CLK_KHZ
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  // timing and enable pins
  input wire logic bit_clock_pin,
  input wire logic frame_pulse_pin,
  input wire logic serial_output_enable_pin,
  // local serial pins
  input wire logic [1:0] local_serial_in,
  output logic [1:0] local_serial_out,
  output logic [1:0] local_serial_oe,
  // expansion pins
  input wire logic exp_stream_a_in,
  output logic exp_stream_a_out,
  output logic exp_stream_a_oe,
  input wire logic exp_stream_b_in,
  output logic exp_stream_b_out,
  output logic exp_stream_b_oe,
  // link configuration
  input wire logic multi_chip_link_mode,
  input wire logic [1:0] exp_rate,
  // hdlc controller pins
  input wire logic tx_packet_end_strobe,
  input wire logic rx_packet_end_strobe,
  input wire logic dchan_serial_in,
  output logic tx_bit_clock_gate,
  output logic rx_bit_clock_gate,
  // hdlc user side
  input wire logic hdlc_enable,
  input wire logic [4:0] hdlc_slot,
  output logic tx_packet_sent,
  output logic rx_packet_done,
  output logic [7:0] dchan_data,
  output logic dchan_valid,
  // local user side
  input wire logic [7:0] local_tx_data0,
  input wire logic [7:0] local_tx_data1,
  input wire logic [1:0] local_tx_float,
  output logic [4:0] local_slot,
  output logic [7:0] local_rx_data0,
  output logic [7:0] local_rx_data1,
  output logic local_rx_valid,
  // expansion user side
  input wire logic [7:0] exp_tx_data_a,
  input wire logic [7:0] exp_tx_data_b,
  input wire logic [1:0] exp_tx_float,
  output logic [6:0] exp_slot,
  output logic [7:0] exp_rx_data_a,
  output logic [7:0] exp_rx_data_b,
  output logic exp_rx_valid
);
  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  if (CLK_KHZ < tsp_pkg::MIN_CLK_PER_TICK * tsp_pkg::BIT_CLK_KHZ) begin
    $error("clock too slow to follow the bit clock pin");
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // shift from tick count to bit count for a rate
  function automatic logic [1:0] shift_of(input logic [1:0] rate);
    case (rate)
      tsp_pkg::RATE_2M: return 2'h2;
      tsp_pkg::RATE_4M: return 2'h1;
      default: return 2'h0;
    endcase
  endfunction

  function automatic logic [1:0] sub_of(input logic [9:0] c,
                                        input logic [1:0] sh);
    return c[1:0] & 2'((3'h1 << sh) - 3'h1);
  endfunction

  function automatic logic [1:0] mid_of(input logic [1:0] sh);
    return (sh == 2'h2) ? 2'h1 : 2'h0;
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  localparam int W = tsp_pkg::SYNC_W;
  logic [W-1:0] pin_v, s1, s2, s3, st;
  assign pin_v = {rx_packet_end_strobe, tx_packet_end_strobe,
                  exp_stream_b_in, exp_stream_a_in, dchan_serial_in,
                  local_serial_in, serial_output_enable_pin,
                  frame_pulse_pin, bit_clock_pin};

  // a lane changes only once stages two and three agree
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      st <= '0;
    end else if (ce) begin
      s1 <= pin_v;
      s2 <= s1;
      s3 <= s2;
      st <= ((s2 ~^ s3) & s3) | ((s2 ^ s3) & st);
    end
  end

  logic [1:0] loc_in;
  assign loc_in = st[tsp_pkg::SY_LOC +: 2];

  // ----------------------------------------------------------------
  // bit ticks and frame counter
  // ----------------------------------------------------------------
  logic c8_prev, fp_hold, rise, fall, fp_start;
  logic [9:0] cnt, next_cnt;
  assign rise = st[tsp_pkg::SY_C8] & ~c8_prev;
  assign fall = ~st[tsp_pkg::SY_C8] & c8_prev;
  assign fp_start = st[tsp_pkg::SY_FP] & ~fp_hold;
  assign next_cnt = fp_start ? tsp_pkg::CNT_RST : cnt + 10'h001;

  // a long frame pulse restarts the frame only once
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      c8_prev <= 1'b0;
      fp_hold <= 1'b0;
      cnt <= tsp_pkg::CNT_RST;
    end else if (ce) begin
      c8_prev <= st[tsp_pkg::SY_C8];
      if (rise) begin
        fp_hold <= st[tsp_pkg::SY_FP];
        cnt <= next_cnt;
      end
    end
  end

  // drive on a rising tick at bit start, sample mid-bit on a falling one
  logic drive_loc, samp_loc, loc_first;
  assign drive_loc = rise && next_cnt[1:0] == 2'h0;
  assign samp_loc = fall && cnt[1:0] == 2'h1;
  assign loc_first = drive_loc && next_cnt[4:2] == 3'h0;

  // ----------------------------------------------------------------
  // local streams
  // ----------------------------------------------------------------
  logic [7:0] loc_tx_in [2];
  logic [7:0] loc_txb [2];
  logic [7:0] loc_sr [2];
  logic [1:0] loc_flt;
  assign loc_tx_in[0] = local_tx_data0;
  assign loc_tx_in[1] = local_tx_data1;

  // transmit, msb first; byte and float latched at slot start
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      loc_txb <= '{default: tsp_pkg::BYTE_RST};
      loc_flt <= 2'h0;
      local_serial_out <= 2'h0;
      local_serial_oe <= 2'h0;
    end else if (ce) begin
      for (int i = 0; i < 2; i++) begin
        if (loc_first) begin
          loc_txb[i] <= loc_tx_in[i];
          loc_flt[i] <= local_tx_float[i];
          local_serial_out[i] <= loc_tx_in[i][7];
        end else if (drive_loc) begin
          local_serial_out[i] <= loc_txb[i][3'h7 - next_cnt[4:2]];
        end
      end
      local_serial_oe <= {2{st[tsp_pkg::SY_OE]}} & ~loc_flt;
    end
  end

  // receive; a whole byte shows with a one-cycle valid
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      loc_sr <= '{default: tsp_pkg::BYTE_RST};
      local_rx_data0 <= tsp_pkg::BYTE_RST;
      local_rx_data1 <= tsp_pkg::BYTE_RST;
      local_rx_valid <= 1'b0;
    end else if (ce) begin
      local_rx_valid <= 1'b0;
      if (samp_loc) begin
        loc_sr[0] <= {loc_sr[0][6:0], loc_in[0]};
        loc_sr[1] <= {loc_sr[1][6:0], loc_in[1]};
        if (cnt[4:2] == 3'h7) begin
          local_rx_data0 <= {loc_sr[0][6:0], loc_in[0]};
          local_rx_data1 <= {loc_sr[1][6:0], loc_in[1]};
          local_rx_valid <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // hdlc gates, d-channel and packet ends
  // ----------------------------------------------------------------
  // gates follow the slot count, so they cover all 8 bits of the slot
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      local_slot <= 5'h00;
      tx_bit_clock_gate <= 1'b0;
      rx_bit_clock_gate <= 1'b0;
    end else if (ce) begin
      local_slot <= cnt[9:5];
      tx_bit_clock_gate <= hdlc_enable && cnt[9:5] == hdlc_slot;
      rx_bit_clock_gate <= hdlc_enable && cnt[9:5] == hdlc_slot;
    end
  end

  logic [7:0] dch_sr;
  logic tx_packet_end_strobe_prev, rx_packet_end_strobe_prev;

  // strobes are edge-detected; a held strobe counts once
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dch_sr <= tsp_pkg::BYTE_RST;
      dchan_data <= tsp_pkg::BYTE_RST;
      dchan_valid <= 1'b0;
      tx_packet_end_strobe_prev <= 1'b0;
      rx_packet_end_strobe_prev <= 1'b0;
      tx_packet_sent <= 1'b0;
      rx_packet_done <= 1'b0;
    end else if (ce) begin
      dchan_valid <= 1'b0;
      if (samp_loc && rx_bit_clock_gate) begin
        dch_sr <= {dch_sr[6:0], st[tsp_pkg::SY_DCH]};
        if (cnt[4:2] == 3'h7) begin
          dchan_data <= {dch_sr[6:0], st[tsp_pkg::SY_DCH]};
          dchan_valid <= 1'b1;
        end
      end
      tx_packet_end_strobe_prev <= st[tsp_pkg::SY_TX_PACKET_END_STROBE];
      rx_packet_end_strobe_prev <= st[tsp_pkg::SY_RX_PACKET_END_STROBE];
      tx_packet_sent <= st[tsp_pkg::SY_TX_PACKET_END_STROBE] & ~tx_packet_end_strobe_prev;
      rx_packet_done <= st[tsp_pkg::SY_RX_PACKET_END_STROBE] & ~rx_packet_end_strobe_prev;
    end
  end

  // ----------------------------------------------------------------
  // expansion streams
  // ----------------------------------------------------------------
  // multi-chip mode runs at the full rate whatever the rate select
  logic [1:0] esh;
  logic [9:0] nidx, cidx;
  logic drive_exp, samp_exp;
  assign esh = shift_of(multi_chip_link_mode ? tsp_pkg::RATE_8M
                                              : exp_rate);
  assign nidx = next_cnt >> esh;
  assign cidx = cnt >> esh;
  assign drive_exp = rise && sub_of(next_cnt, esh) == 2'h0;
  assign samp_exp = fall && sub_of(cnt, esh) == mid_of(esh);

  logic [7:0] exp_tx_in [2];
  logic [7:0] exp_txb [2];
  logic [1:0] exp_flt;
  logic [1:0] exp_bits;
  assign exp_tx_in[0] = exp_tx_data_a;
  assign exp_tx_in[1] = exp_tx_data_b;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      exp_txb <= '{default: tsp_pkg::BYTE_RST};
      exp_flt <= 2'h0;
      exp_bits <= 2'h0;
    end else if (ce && drive_exp) begin
      for (int i = 0; i < 2; i++) begin
        if (nidx[2:0] == 3'h0) begin
          exp_txb[i] <= exp_tx_in[i];
          exp_flt[i] <= exp_tx_float[i];
          exp_bits[i] <= exp_tx_in[i][7];
        end else begin
          exp_bits[i] <= exp_txb[i][3'h7 - nidx[2:0]];
        end
      end
    end
  end

  // stream b never drives outside multi-chip mode
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      exp_stream_a_out <= 1'b0;
      exp_stream_b_out <= 1'b0;
      exp_stream_a_oe <= 1'b0;
      exp_stream_b_oe <= 1'b0;
    end else if (ce) begin
      exp_stream_a_out <= exp_bits[0];
      exp_stream_b_out <= exp_bits[1];
      exp_stream_a_oe <= st[tsp_pkg::SY_OE] & ~exp_flt[0];
      exp_stream_b_oe <= st[tsp_pkg::SY_OE] & ~exp_flt[1]
                         & multi_chip_link_mode;
    end
  end

  logic [7:0] exa_sr, exb_sr;

  // stream a is only heard in multi-chip mode; own slots read back
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      exa_sr <= tsp_pkg::BYTE_RST;
      exb_sr <= tsp_pkg::BYTE_RST;
      exp_rx_data_a <= tsp_pkg::BYTE_RST;
      exp_rx_data_b <= tsp_pkg::BYTE_RST;
      exp_rx_valid <= 1'b0;
      exp_slot <= 7'h00;
    end else if (ce) begin
      exp_rx_valid <= 1'b0;
      exp_slot <= cidx[9:3];
      if (samp_exp) begin
        exa_sr <= {exa_sr[6:0], st[tsp_pkg::SY_EXA]};
        exb_sr <= {exb_sr[6:0], st[tsp_pkg::SY_EXB]};
        if (cidx[2:0] == 3'h7) begin
          if (multi_chip_link_mode) begin
            exp_rx_data_a <= {exa_sr[6:0], st[tsp_pkg::SY_EXA]};
          end
          exp_rx_data_b <= {exb_sr[6:0], st[tsp_pkg::SY_EXB]};
          exp_rx_valid <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_reset_float: assert property (@(posedge clk)
    !resetn |-> (local_serial_oe == 2'h0 && !exp_stream_a_oe
                 && !exp_stream_b_oe))
    else $error("outputs driven during reset");

  a_pin_float: assert property (@(posedge clk)
    disable iff (!resetn) (ce && !st[tsp_pkg::SY_OE]) |=>
      (local_serial_oe == 2'h0 && !exp_stream_a_oe && !exp_stream_b_oe))
    else $error("output enabled with enable pin low");

  a_b_input_only: assert property (@(posedge clk)
    disable iff (!resetn) ($past(ce) && !multi_chip_link_mode
      && !$past(multi_chip_link_mode)) |-> !exp_stream_b_oe)
    else $error("stream b driven in timeslot mode");

  a_frame_zero: assert property (@(posedge clk)
    disable iff (!resetn) (ce && rise && fp_start) |=> cnt == 10'h000)
    else $error("frame pulse did not restart slot zero");

  a_gate_slot: assert property (@(posedge clk)
    disable iff (!resetn) ($past(ce) && tx_bit_clock_gate) |->
      (local_slot == $past(hdlc_slot) && $past(hdlc_enable)))
    else $error("gate outside allocated slot");

  a_rx_gate_slot: assert property (@(posedge clk)
    disable iff (!resetn) ($past(ce) && rx_bit_clock_gate) |->
      (local_slot == $past(hdlc_slot) && $past(hdlc_enable)))
    else $error("rx gate outside allocated slot");

  a_first_bit: assert property (@(posedge clk)
    disable iff (!resetn) ($past(ce) && $past(loc_first)) |->
      local_serial_out[0] == $past(local_tx_data0[7]))
    else $error("slot did not start with msb");

  a_rx_last_bit: assert property (@(posedge clk)
    disable iff (!resetn) ($past(ce) && local_rx_valid) |->
      local_rx_data0[0] == $past(loc_in[0]))
    else $error("received byte lost its last bit");

  a_rx_end_pulse: assert property (@(posedge clk)
    disable iff (!resetn) (ce && rx_packet_done) |=> !rx_packet_done)
    else $error("packet end longer than one cycle");

  c_gate_on: cover property (@(posedge clk) disable iff (!resetn)
    $rose(tx_bit_clock_gate));
  c_dchan_byte: cover property (@(posedge clk) disable iff (!resetn)
    dchan_valid);
  c_exp_multi: cover property (@(posedge clk) disable iff (!resetn)
    exp_rx_valid && multi_chip_link_mode);
  c_tx_sent: cover property (@(posedge clk) disable iff (!resetn)
    tx_packet_sent);
endmodule

//--- design/tsp_pkg.sv
package tsp_pkg;
  // ----------------------------------------------------------------
  // clock and line timing
  // ----------------------------------------------------------------
  localparam int CLK_KHZ = 50000;
  localparam int BIT_CLK_KHZ = 8192; // expansion bit clock on its pin
  localparam int MIN_CLK_PER_TICK = 4; // sync needs slack per half
  localparam int LOCAL_KBPS = 2048;
  localparam int CHANS_LOCAL = 32;
  localparam int SLOT_BITS = 8;
  localparam int TICKS_PER_FRAME = 1024; // 8.192 MHz ticks in 125 us
  localparam int CNT_W = 10;
  localparam int LOC_SLOT_W = 5;
  localparam int EXP_SLOT_W = 7;

  // ----------------------------------------------------------------
  // expansion rate codes
  // ----------------------------------------------------------------
  localparam logic [1:0] RATE_2M = 2'h0;
  localparam logic [1:0] RATE_4M = 2'h1;
  localparam logic [1:0] RATE_8M = 2'h2;

  // ----------------------------------------------------------------
  // synchroniser lanes
  // ----------------------------------------------------------------
  localparam int SY_C8 = 0;
  localparam int SY_FP = 1;
  localparam int SY_OE = 2;
  localparam int SY_LOC = 3; // two lanes
  localparam int SY_DCH = 5;
  localparam int SY_EXA = 6;
  localparam int SY_EXB = 7;
  localparam int SY_TX_PACKET_END_STROBE = 8;
  localparam int SY_RX_PACKET_END_STROBE = 9;
  localparam int SYNC_W = 10;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [CNT_W-1:0] CNT_RST = 10'h000;
  localparam logic [7:0] BYTE_RST = 8'h00;
endpackage

//--- testbench/tsp_far_end.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// far side: timing source, codec streams and hdlc controller
// ----------------------------------------------------------------
module tsp_far_end (
  // bench commands
  input wire logic [1:0] exp_rate,
  input wire logic multi_mode,
  input wire logic tx_end_go,
  input wire logic rx_end_go,
  // timing pins
  output logic bit_clock_pin,
  output logic frame_pulse_pin,
  output logic [9:0] tick,
  // data pins
  output logic [1:0] local_serial_in,
  output logic dchan_serial_in,
  output logic exp_a_drive,
  output logic exp_b_drive,
  // hdlc strobes
  output logic tx_packet_end_strobe,
  output logic rx_packet_end_strobe
);
  localparam logic [7:0] DCH_BYTE = 8'hd2;
  localparam logic [7:0] EXP_BYTE = 8'h69;
  logic [7:0] lb;
  logic [9:0] idx;
  int sh;

  // start near frame end so the first frame pulse comes early
  initial begin
    bit_clock_pin = 1'b0;
    frame_pulse_pin = 1'b0;
    tick = 10'h3f0;
    local_serial_in = 2'h0;
    dchan_serial_in = 1'b0;
    exp_a_drive = 1'b0;
    exp_b_drive = 1'b0;
    tx_packet_end_strobe = 1'b0;
    rx_packet_end_strobe = 1'b0;
  end

  // tdm bit clock runs free, phase unrelated to clk
  always #61 bit_clock_pin = ~bit_clock_pin;

  // frame pulse straddles the rise that opens tick 0
  always @(negedge bit_clock_pin) begin
    frame_pulse_pin <= (tick == 10'h3ff);
  end

  // streams change at the start of each bit, msb first
  always @(posedge bit_clock_pin) begin
    tick = tick + 10'h001;
    if (tick[1:0] == 2'h0) begin
      for (int i = 0; i < 2; i++) begin
        lb = {i[0], tick[9:5], 2'h1};
        local_serial_in[i] <= lb[3'h7 - tick[4:2]];
      end
      dchan_serial_in <= DCH_BYTE[3'h7 - tick[4:2]];
    end
    sh = multi_mode ? 0 : (exp_rate == 2'h0) ? 2 : (exp_rate == 2'h1) ? 1 : 0;
    idx = tick >> sh;
    if ((tick & ((10'h001 << sh) - 10'h001)) == 10'h000) begin
      exp_b_drive <= EXP_BYTE[3'h7 - idx[2:0]];
      // released in timeslot mode: toggles so a stale level never passes
      exp_a_drive <= multi_mode ? EXP_BYTE[3'h7 - idx[2:0]] : ~exp_a_drive;
    end
  end

  // strobes last one 2.048 mb/s bit, four ticks
  always @(posedge tx_end_go) begin
    @(posedge bit_clock_pin);
    tx_packet_end_strobe <= 1'b1;
    repeat (4) @(posedge bit_clock_pin);
    tx_packet_end_strobe <= 1'b0;
  end

  always @(posedge rx_end_go) begin
    @(posedge bit_clock_pin);
    rx_packet_end_strobe <= 1'b1;
    repeat (4) @(posedge bit_clock_pin);
    rx_packet_end_strobe <= 1'b0;
  end
endmodule

//--- testbench/test_tsp_stream_port.sv
`timescale 1ns/100ps
module test_tsp_stream_port;
  // ----------------------------------------------------------------
  // pins, user side and bench state
  // ----------------------------------------------------------------
  logic clk = 1'b0;
  logic resetn, ce, oe_pin, multi, tx_go, rx_go, hdlc_en, gate_chk;
  logic [1:0] rate, loc_float, exp_float, lsi, lso, lsoe, got_oe;
  logic [4:0] hdlc_slot, lslot, held;
  logic [6:0] eslot;
  logic [7:0] ltx0, ltx1, ddata, lrx0, lrx1, erx_a, erx_b;
  logic [7:0] cap0, cap1, got0, got1, acap, got_a;
  logic [9:0] tick;
  logic bclk, fpulse, dch, a_drv, b_drv, tx_end, rx_end;
  logic a_out, a_oe, b_out, b_oe, a_in, b_in, txg, rxg;
  logic tx_sent, rx_done, dvalid, lvalid, evalid;
  int fails = 0, checks = 0, cycles = 0, tx_pulses = 0, rx_pulses = 0;
  logic [4:0] row_slot [4] = '{5'h00, 5'h01, 5'h11, 5'h1f};
  logic [7:0] row_rx0 [4] = '{8'h01, 8'h05, 8'h45, 8'h7d};
  logic [7:0] row_rx1 [4] = '{8'h81, 8'h85, 8'hc5, 8'hfd};

  always #10 clk = ~clk;
  // shared expansion wires: whoever enables drives
  assign a_in = a_oe ? a_out : a_drv;
  assign b_in = b_oe ? b_out : b_drv;

  tsp_stream_port uut (.clk(clk), .resetn(resetn), .ce(ce),
    .bit_clock_pin(bclk), .frame_pulse_pin(fpulse),
    .serial_output_enable_pin(oe_pin), .local_serial_in(lsi),
    .local_serial_out(lso), .local_serial_oe(lsoe),
    .exp_stream_a_in(a_in), .exp_stream_a_out(a_out),
    .exp_stream_a_oe(a_oe), .exp_stream_b_in(b_in),
    .exp_stream_b_out(b_out), .exp_stream_b_oe(b_oe),
    .multi_chip_link_mode(multi), .exp_rate(rate),
    .tx_packet_end_strobe(tx_end), .rx_packet_end_strobe(rx_end),
    .dchan_serial_in(dch), .tx_bit_clock_gate(txg),
    .rx_bit_clock_gate(rxg), .hdlc_enable(hdlc_en),
    .hdlc_slot(hdlc_slot), .tx_packet_sent(tx_sent),
    .rx_packet_done(rx_done), .dchan_data(ddata), .dchan_valid(dvalid),
    .local_tx_data0(ltx0), .local_tx_data1(ltx1),
    .local_tx_float(loc_float), .local_slot(lslot),
    .local_rx_data0(lrx0), .local_rx_data1(lrx1),
    .local_rx_valid(lvalid), .exp_tx_data_a(8'ha5),
    .exp_tx_data_b(8'h5a), .exp_tx_float(exp_float), .exp_slot(eslot),
    .exp_rx_data_a(erx_a), .exp_rx_data_b(erx_b), .exp_rx_valid(evalid));

  tsp_far_end far (.exp_rate(rate), .multi_mode(multi),
    .tx_end_go(tx_go), .rx_end_go(rx_go), .bit_clock_pin(bclk),
    .frame_pulse_pin(fpulse), .tick(tick), .local_serial_in(lsi),
    .dchan_serial_in(dch), .exp_a_drive(a_drv), .exp_b_drive(b_drv),
    .tx_packet_end_strobe(tx_end), .rx_packet_end_strobe(rx_end));

  // ----------------------------------------------------------------
  // compare, report and close
  // ----------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    checks++;
    if (seen !== want) begin
      fails++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, want);
    end
  endtask

  task automatic results();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // inputs move 1 ns after the edge so no race with the design
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wait_exp(input int n);
    repeat (n) begin
      step(1);
      while (evalid !== 1'b1) step(1);
    end
  endtask

  // cycle ceiling, about two and a half times the expected run; strobe pulse counts
  always @(posedge clk) begin
    cycles++;
    if (tx_sent === 1'b1) tx_pulses++;
    if (rx_done === 1'b1) rx_pulses++;
    if (cycles == 90000) begin
      fails++;
      results();
    end
  end

  // mid-bit capture of local outputs and gate check
  always @(negedge bclk) begin
    // stream a lags one tick, so a tick-0 edge holds the last full slot
    acap = {acap[6:0], a_out};
    if (tick[2:0] == 3'h0) got_a = acap;
    if (tick[1:0] == 2'h2) begin
      cap0 = {cap0[6:0], lso[0]};
      cap1 = {cap1[6:0], lso[1]};
      if (tick[4:2] == 3'h0) got_oe = lsoe;
      if (tick[4:2] == 3'h7) begin
        got0 = cap0;
        got1 = cap1;
      end
      if (gate_chk) begin
        check({6'h00, txg, rxg},
          {6'h00, {2{hdlc_en && tick[9:5] == hdlc_slot}}});
      end
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    resetn = 1'b0;
    ce = 1'b1;
    oe_pin = 1'b1;
    multi = 1'b0;
    rate = 2'h0;
    tx_go = 1'b0;
    rx_go = 1'b0;
    hdlc_en = 1'b1;
    hdlc_slot = 5'h05;
    ltx0 = 8'h96;
    ltx1 = 8'h3c;
    loc_float = 2'h0;
    exp_float = 2'h0;
    gate_chk = 1'b0;
    repeat (10) @(posedge clk);
    check({2'h0, lsoe, a_oe, b_oe, txg, rxg}, 8'h00);
    #1 resetn = 1'b1;
    @(negedge fpulse);
    step(1);
    gate_chk = 1'b1;
    $display("reset test done");
    for (int r = 0; r < 4; r++) begin
      while (lslot !== row_slot[r] + 5'h02) step(1);
      hdlc_slot = row_slot[r];
      while (dvalid !== 1'b1) step(1);
      check(ddata, 8'hd2);
      while (!(lvalid === 1'b1 && lslot === row_slot[r])) step(1);
      check(lrx0, row_rx0[r]);
      check(lrx1, row_rx1[r]);
      $display("row %0d done", r);
    end
    @(negedge bclk iff tick[4:0] == 5'h1f);
    check(got0, 8'h96);
    check(got1, 8'h3c);
    check({6'h00, got_oe}, 8'h03);
    step(1);
    loc_float = 2'h2;
    repeat (2) @(negedge bclk iff tick[4:0] == 5'h1f);
    check({6'h00, got_oe}, 8'h01);
    check(got0, 8'h96);
    step(1);
    oe_pin = 1'b0;
    step(10);
    check({4'h0, lsoe, a_oe, b_oe}, 8'h00);
    oe_pin = 1'b1;
    loc_float = 2'h0;
    $display("local transmit test done");
    tx_go = 1'b1;
    rx_go = 1'b1;
    repeat (12) @(posedge bclk);
    step(1);
    check(8'(tx_pulses), 8'h01);
    check(8'(rx_pulses), 8'h01);
    tx_go = 1'b0;
    rx_go = 1'b0;
    $display("packet end test done");
    for (int k = 0; k < 3; k++) begin
      rate = 2'(k);
      wait_exp(3);
      check(erx_b, 8'h69);
      check({6'h00, a_oe, b_oe}, 8'h02);
      if (k == 2) check(got_a, 8'ha5);
    end
    multi = 1'b1;
    wait_exp(3);
    check({6'h00, a_oe, b_oe}, 8'h03);
    check(got_a, 8'ha5);
    exp_float = 2'h3;
    wait_exp(4);
    check(erx_a, 8'h69);
    check(erx_b, 8'h69);
    @(negedge bclk iff tick[2:0] == 3'h4);
    check({1'b0, eslot}, {1'b0, tick[9:3]});
    step(1);
    // disabled hdlc: the next slot must pass with both gates low
    hdlc_en = 1'b0;
    hdlc_slot = lslot + 5'h01;
    step(300);
    check({6'h00, txg, rxg}, 8'h00);
    $display("expansion test done");
    gate_chk = 1'b0;
    ce = 1'b0;
    held = lslot;
    step(300);
    check({3'h0, lslot}, {3'h0, held});
    ce = 1'b1;
    $display("clock enable test done");
    resetn = 1'b0;
    step(2);
    check({2'h0, lsoe, a_oe, b_oe, txg, rxg}, 8'h00);
    check({3'h0, lslot}, 8'h00);
    $display("mid-run reset test done");
    results();
  end
endmodule
